// ### hdl/memory_map_commit_control.sv
// memory-map control registers with key-code commit, and address steering
// assumes the cpu end drives one register strobe per cycle at most

// Operation
// - committed ram bit maps code ram window
// - vectors at top of code space normally
// - relocated vectors sit at 0x01A0 and 0x01C8
// - ram bit inert until map key written
// - commit register decodes keys, others ignored
// - software writes commit register plainly only
// - reset-disable key needs normal mode, fc/4; not checked, key commits in any mode
// - flag-clear key needs normal mode, fc/4; not checked, key commits in any mode
// - config upper bits zero, all reset zero
// - commit address reads status of committed bits
// - status shows committed vector, ram and reset-disable
// - vectors into ram need both bits set
// - ram loader never clears vector relocation
// - boot rom unmapped after reset
// - committed boot bit maps boot rom window
// - only 2 Kbytes of boot rom outside serial
// - unmapped boot range fetches flash or opcode
// - serial mode forces ram into code space
// - data space ram always mapped
// - flash control double buffered, active copy readable
module memory_map_commit_control #(
    parameter logic [15:0] FLASH_LOW     = mm_pkg::FLASH_LO,
    parameter logic [15:0] BOOT_WIDE_HI  = mm_pkg::BOOT_SERIAL_HI
) (
    input  wire logic  clock_in,
    input  wire logic  sys_rst_in,
    map_link_if.dev    link,
    input  wire logic  serial_prog_mode_in,
    input  wire logic  reset_flag_clear_in,
    output logic       ram_in_code_active_out,
    output logic       vector_relocate_active_out,
    output logic       reset_disable_out,
    output logic       reset_flag_clear_out,
    output logic       boot_rom_map_out
);
    logic [2:0]          cfg_pending;
    logic                ram_in_code_active;
    logic                vector_relocate_active;
    logic                reset_disable;
    logic                reset_flag_clear;
    logic [7:0]          flash_map_control;
    logic [7:0]          flash_map_active_readback;

    logic                wr_cfg;
    logic                wr_key;
    logic                wr_fctl;
    logic                wr_fkey;
    logic                commit_map;
    logic                commit_fclr;
    logic                commit_rstoff;
    logic                commit_flash;
    logic                rd_cfg;
    logic                rd_status;
    logic                rd_fctl;
    logic                rd_frb;
    logic [7:0]          status;
    logic [7:0]          next_rdata;

    logic                ram_code_on;
    logic                boot_on;
    logic [15:0]         boot_hi;
    logic                code_ram_hit;
    logic                code_boot_hit;
    logic                data_ram_hit;
    logic                data_boot_hit;
    logic                sfr1_hit;
    logic                sfr2_hit;
    logic                sfr3_hit;
    mm_pkg::target_type  next_code_target;
    mm_pkg::target_type  next_data_target;
    logic [15:0]         vec_base;
    logic [15:0]         next_vec_addr;

    // register decode
    assign wr_cfg  = link.reg_wr && (link.reg_addr == mm_pkg::CFG_ADDR);
    assign wr_key  = link.reg_wr && (link.reg_addr == mm_pkg::KEY_ADDR);
    assign wr_fctl = link.reg_wr && (link.reg_addr == mm_pkg::FLASH_CTRL_ADDR);
    assign wr_fkey = link.reg_wr && (link.reg_addr == mm_pkg::FLASH_KEY_ADDR);
    assign rd_cfg    = link.reg_rd && (link.reg_addr == mm_pkg::CFG_ADDR);
    assign rd_status = link.reg_rd && (link.reg_addr == mm_pkg::KEY_ADDR);
    assign rd_fctl   = link.reg_rd && (link.reg_addr == mm_pkg::FLASH_CTRL_ADDR);
    assign rd_frb    = link.reg_rd && (link.reg_addr == mm_pkg::FLASH_RB_ADDR);

    // key decode; other codes ignored
    assign commit_map    = wr_key && (link.reg_wdata == mm_pkg::KEY_MAP);
    assign commit_fclr   = wr_key && (link.reg_wdata == mm_pkg::KEY_FCLR);
    // no mode or gear check here: timing of these two is software's duty
    assign commit_rstoff = wr_key && (link.reg_wdata == mm_pkg::KEY_RSTOFF);
    assign commit_flash  = wr_fkey && (link.reg_wdata == mm_pkg::KEY_FLASH);

    // pending and committed copies
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            cfg_pending               <= mm_pkg::CFG_RESET;
            ram_in_code_active        <= 1'b0;
            vector_relocate_active    <= 1'b0;
            reset_disable             <= 1'b0;
            reset_flag_clear          <= 1'b0;
            flash_map_control         <= mm_pkg::FLASH_RESET;
            flash_map_active_readback <= mm_pkg::FLASH_RESET;
        end else begin
            if (wr_cfg) begin
                cfg_pending <= link.reg_wdata[2:0];
            end
            if (commit_map) begin
                ram_in_code_active     <= cfg_pending[mm_pkg::BIT_RAM];
                vector_relocate_active <= cfg_pending[mm_pkg::BIT_VEC];
            end
            if (commit_rstoff) begin
                reset_disable <= cfg_pending[mm_pkg::BIT_RSTOFF];
            end
            if (commit_fclr) begin
                reset_flag_clear <= reset_flag_clear_in;
            end
            if (wr_fctl) begin
                flash_map_control <= link.reg_wdata;
            end
            if (commit_flash) begin
                flash_map_active_readback <= flash_map_control;
            end
        end
    end

    // status shows committed bits only, upper bits zero
    assign status = {5'h00, vector_relocate_active, ram_in_code_active,
                     reset_disable};

    // commit address reads back status
    assign next_rdata = rd_cfg    ? {5'h00, cfg_pending} :
                        rd_status ? status :
                        rd_fctl   ? flash_map_control :
                        rd_frb    ? flash_map_active_readback :
                        8'h00;

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            link.reg_rdata <= 8'h00;
        end else begin
            link.reg_rdata <= next_rdata;
        end
    end

    // map state from committed copies and serial mode only
    assign ram_code_on = ram_in_code_active || serial_prog_mode_in;
    assign boot_on = flash_map_active_readback[mm_pkg::BIT_BOOT];
    assign boot_hi = serial_prog_mode_in ? BOOT_WIDE_HI : mm_pkg::BOOT_HI;

    addr_range_match #(.W(16)) u_code_ram (
        .addr_in (link.code_addr),
        .lo_in   (mm_pkg::RAM_LO),
        .hi_in   (mm_pkg::RAM_HI),
        .hit_out (code_ram_hit)
    );
    addr_range_match #(.W(16)) u_code_boot (
        .addr_in (link.code_addr),
        .lo_in   (mm_pkg::BOOT_LO),
        .hi_in   (boot_hi),
        .hit_out (code_boot_hit)
    );
    addr_range_match #(.W(16)) u_data_ram (
        .addr_in (link.data_addr),
        .lo_in   (mm_pkg::RAM_LO),
        .hi_in   (mm_pkg::RAM_HI),
        .hit_out (data_ram_hit)
    );
    addr_range_match #(.W(16)) u_data_boot (
        .addr_in (link.data_addr),
        .lo_in   (mm_pkg::BOOT_LO),
        .hi_in   (boot_hi),
        .hit_out (data_boot_hit)
    );
    addr_range_match #(.W(16)) u_sfr1 (
        .addr_in (link.data_addr),
        .lo_in   (mm_pkg::SFR1_LO),
        .hi_in   (mm_pkg::SFR1_HI),
        .hit_out (sfr1_hit)
    );
    addr_range_match #(.W(16)) u_sfr2 (
        .addr_in (link.data_addr),
        .lo_in   (mm_pkg::SFR2_LO),
        .hi_in   (mm_pkg::SFR2_HI),
        .hit_out (sfr2_hit)
    );
    addr_range_match #(.W(16)) u_sfr3 (
        .addr_in (link.data_addr),
        .lo_in   (mm_pkg::SFR3_LO),
        .hi_in   (mm_pkg::SFR3_HI),
        .hit_out (sfr3_hit)
    );

    // unmapped code ram window and absent low flash both trap
    assign next_code_target =
        code_ram_hit  ? (ram_code_on ? mm_pkg::TGT_RAM : mm_pkg::TGT_TRAP) :
        (code_boot_hit && boot_on) ? mm_pkg::TGT_BOOT :
        (link.code_addr >= FLASH_LOW) ? mm_pkg::TGT_FLASH :
        (link.code_addr >= mm_pkg::BOOT_LO) ? mm_pkg::TGT_TRAP :
        mm_pkg::TGT_NONE;

    // data space: sfr first, ram always present
    assign next_data_target =
        (sfr1_hit || sfr2_hit || sfr3_hit) ? mm_pkg::TGT_SFR :
        data_ram_hit ? mm_pkg::TGT_RAM :
        (data_boot_hit && boot_on) ? mm_pkg::TGT_BOOT :
        (link.data_addr >= FLASH_LOW) ? mm_pkg::TGT_FLASH :
        mm_pkg::TGT_NONE;

    // reset vector never moves, even when the tables are relocated
    assign vec_base = !link.vec_is_irq ?
                          (vector_relocate_active ? mm_pkg::VCALL_REL
                                                  : mm_pkg::VCALL_STD) :
                      (link.vec_index == mm_pkg::RESET_VEC_IDX) ? mm_pkg::VIRQ_STD :
                      (vector_relocate_active ? mm_pkg::VIRQ_REL
                                              : mm_pkg::VIRQ_STD);
    assign next_vec_addr = vec_base + {10'h000,
                           link.vec_is_irq ? link.vec_index : {1'b0, link.vec_index[3:0]},
                           1'b0};

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            link.code_target <= mm_pkg::TGT_NONE;
            link.data_target <= mm_pkg::TGT_NONE;
            link.vec_addr    <= 16'h0000;
        end else begin
            link.code_target <= next_code_target;
            link.data_target <= next_data_target;
            link.vec_addr    <= next_vec_addr;
        end
    end

    assign ram_in_code_active_out     = ram_in_code_active;
    assign vector_relocate_active_out = vector_relocate_active;
    assign reset_disable_out          = reset_disable;
    assign reset_flag_clear_out       = reset_flag_clear;
    assign boot_rom_map_out           = boot_on;
endmodule : memory_map_commit_control

// ### hdl/mm_pkg.sv
// constants shared by the memory-map control device end and the cpu end
// assumes 16-bit code and data addresses and 8-bit registers
package mm_pkg;
    // register addresses
    localparam logic [15:0] CFG_ADDR        = 16'h0FDE;
    localparam logic [15:0] KEY_ADDR        = 16'h0FDF;
    localparam logic [15:0] FLASH_CTRL_ADDR = 16'h0FD0;
    localparam logic [15:0] FLASH_KEY_ADDR  = 16'h0FD1;
    localparam logic [15:0] FLASH_RB_ADDR   = 16'h0FD2;
    // commit key codes
    localparam logic [7:0]  KEY_MAP         = 8'hD4;
    localparam logic [7:0]  KEY_FCLR        = 8'h71;
    localparam logic [7:0]  KEY_RSTOFF      = 8'hB2;
    localparam logic [7:0]  KEY_FLASH       = 8'hD5;
    // field positions and reset values
    localparam int          BIT_RSTOFF      = 0;
    localparam int          BIT_RAM         = 1;
    localparam int          BIT_VEC         = 2;
    localparam int          BIT_BOOT        = 4;
    localparam logic [2:0]  CFG_RESET       = 3'h0;
    localparam logic [7:0]  FLASH_RESET     = 8'h40;
    // address windows
    localparam logic [15:0] RAM_LO          = 16'h0040;
    localparam logic [15:0] RAM_HI          = 16'h0C3F;
    localparam logic [15:0] BOOT_LO         = 16'h1000;
    localparam logic [15:0] BOOT_HI         = 16'h17FF;
    localparam logic [15:0] BOOT_SERIAL_HI  = 16'h1FFF;
    localparam logic [15:0] FLASH_LO        = 16'h1000;
    localparam logic [15:0] SFR1_LO         = 16'h0000;
    localparam logic [15:0] SFR1_HI         = 16'h003F;
    localparam logic [15:0] SFR2_LO         = 16'h0F00;
    localparam logic [15:0] SFR2_HI         = 16'h0FFF;
    localparam logic [15:0] SFR3_LO         = 16'h0E40;
    localparam logic [15:0] SFR3_HI         = 16'h0EFF;
    // vector table bases, two bytes per entry
    localparam logic [15:0] VCALL_STD       = 16'hFFA0;
    localparam logic [15:0] VIRQ_STD        = 16'hFFC8;
    localparam logic [15:0] VCALL_REL       = 16'h01A0;
    localparam logic [15:0] VIRQ_REL        = 16'h01C8;
    localparam logic [4:0]  RESET_VEC_IDX   = 5'h1B;

    typedef enum logic [2:0] {
        TGT_NONE  = 3'h0,
        TGT_RAM   = 3'h1,
        TGT_FLASH = 3'h2,
        TGT_BOOT  = 3'h3,
        TGT_TRAP  = 3'h4,
        TGT_SFR   = 3'h5
    } target_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_CFG  = 3'h2,
        ST_KEY  = 3'h4
    } helper_state_type;
endpackage : mm_pkg

// ### hdl/map_link_if.sv
// link between the cpu end and the memory-map control device end
// assumes both ends run on one clock; register reads answer one cycle later
interface map_link_if;
    logic [15:0]         reg_addr;
    logic [7:0]          reg_wdata;
    logic                reg_wr;
    logic                reg_rd;
    logic [7:0]          reg_rdata;
    logic [15:0]         code_addr;
    logic [15:0]         data_addr;
    logic                vec_is_irq;
    logic [4:0]          vec_index;
    mm_pkg::target_type  code_target;
    mm_pkg::target_type  data_target;
    logic [15:0]         vec_addr;

    modport dev (
        input  reg_addr, reg_wdata, reg_wr, reg_rd, code_addr, data_addr,
        input  vec_is_irq, vec_index,
        output reg_rdata, code_target, data_target, vec_addr
    );
    modport cpu (
        output reg_addr, reg_wdata, reg_wr, reg_rd, code_addr, data_addr,
        output vec_is_irq, vec_index,
        input  reg_rdata, code_target, data_target, vec_addr
    );
endinterface : map_link_if

// ### hdl/addr_range_match.sv
// inclusive address window compare
// assumes lo is not above hi
module addr_range_match #(
    parameter int W = 16
) (
    input  wire logic [W-1:0] addr_in,
    input  wire logic [W-1:0] lo_in,
    input  wire logic [W-1:0] hi_in,
    output logic              hit_out
);
    assign hit_out = (addr_in >= lo_in) && (addr_in <= hi_in);
endmodule : addr_range_match

// ### hdl/map_cpu_port.sv
// cpu end: software register port, fetch addresses, and a map-commit helper
// assumes the software master keeps one strobe per cycle
module map_cpu_port (
    input  wire logic          clock_in,
    input  wire logic          sys_rst_in,
    map_link_if.cpu            link,
    input  wire logic [15:0]   sw_addr_in,
    input  wire logic [7:0]    sw_wdata_in,
    input  wire logic          sw_wr_in,
    input  wire logic          sw_rd_in,
    output logic [7:0]         sw_rdata_out,
    input  wire logic [15:0]   code_addr_in,
    input  wire logic [15:0]   data_addr_in,
    input  wire logic          vec_is_irq_in,
    input  wire logic [4:0]    vec_index_in,
    output mm_pkg::target_type code_target_out,
    output mm_pkg::target_type data_target_out,
    output logic [15:0]        vec_addr_out,
    input  wire logic          map_req_in,
    input  wire logic          map_ram_in,
    input  wire logic          map_vec_in,
    input  wire logic          ram_loader_in,
    output logic               map_busy_out
);
    mm_pkg::helper_state_type state;
    mm_pkg::helper_state_type next_state;
    logic [7:0]               cfg_value;
    logic                     want_vec;
    logic                     helper_wr;
    logic [15:0]              helper_addr;
    logic [7:0]               helper_wdata;

    // a ram loader keeps relocation on; relocation drags ram mapping along
    assign want_vec = map_vec_in || ram_loader_in;

    always_comb begin
        case (state)
            mm_pkg::ST_IDLE: next_state = map_req_in ? mm_pkg::ST_CFG : mm_pkg::ST_IDLE;
            mm_pkg::ST_CFG:  next_state = mm_pkg::ST_KEY;
            mm_pkg::ST_KEY:  next_state = mm_pkg::ST_IDLE;
            default:         next_state = mm_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            state     <= mm_pkg::ST_IDLE;
            cfg_value <= 8'h00;
        end else begin
            state <= next_state;
            if (state == mm_pkg::ST_IDLE && map_req_in) begin
                cfg_value <= {5'h00, want_vec, map_ram_in || want_vec, 1'b0};
            end
        end
    end

    // helper issues two plain writes, never a read-back-and-modify
    assign helper_wr    = (state == mm_pkg::ST_CFG) || (state == mm_pkg::ST_KEY);
    assign helper_addr  = (state == mm_pkg::ST_KEY) ? mm_pkg::KEY_ADDR : mm_pkg::CFG_ADDR;
    assign helper_wdata = (state == mm_pkg::ST_KEY) ? mm_pkg::KEY_MAP : cfg_value;

    // software strobes are dropped while the helper owns the port
    assign link.reg_wr    = helper_wr || sw_wr_in;
    assign link.reg_rd    = !helper_wr && sw_rd_in;
    assign link.reg_addr  = helper_wr ? helper_addr : sw_addr_in;
    assign link.reg_wdata = helper_wr ? helper_wdata : sw_wdata_in;

    assign link.code_addr  = code_addr_in;
    assign link.data_addr  = data_addr_in;
    assign link.vec_is_irq = vec_is_irq_in;
    assign link.vec_index  = vec_index_in;

    assign sw_rdata_out    = link.reg_rdata;
    assign code_target_out = link.code_target;
    assign data_target_out = link.data_target;
    assign vec_addr_out    = link.vec_addr;
    assign map_busy_out    = (state != mm_pkg::ST_IDLE);
endmodule : map_cpu_port

// ### test/map_link_properties.sv
// checker on the link between the two ends
// assumes one clock; tracks pending and committed bits from link writes
module map_link_properties (
    input wire logic               clock_in,
    input wire logic               sys_rst_in,
    input wire logic               serial_mode,
    input wire logic [15:0]        reg_addr,
    input wire logic [7:0]         reg_wdata,
    input wire logic               reg_wr,
    input wire logic               reg_rd,
    input wire logic [7:0]         reg_rdata,
    input wire logic [15:0]        code_addr,
    input wire logic [15:0]        data_addr,
    input wire logic               vec_is_irq,
    input wire logic [4:0]         vec_index,
    input wire mm_pkg::target_type code_target,
    input wire mm_pkg::target_type data_target,
    input wire logic [15:0]        vec_addr
);
    logic [2:0]  pend;
    logic [2:0]  act;
    wire         cfg_wr   = reg_wr && reg_addr == mm_pkg::CFG_ADDR;
    wire         key_wr   = reg_wr && reg_addr == mm_pkg::KEY_ADDR;
    wire         key_rd   = reg_rd && reg_addr == mm_pkg::KEY_ADDR;
    wire         code_win = code_addr >= mm_pkg::RAM_LO && code_addr <= mm_pkg::RAM_HI;
    wire         data_win = data_addr >= mm_pkg::RAM_LO && data_addr <= mm_pkg::RAM_HI;
    // call table has 16 entries
    wire [15:0]  call2    = {11'h0, vec_index[3:0], 1'b0};
    wire [15:0]  irq2     = {10'h0, vec_index, 1'b0};
    wire [15:0]  rel_irq  = vec_index == 5'h1B ? 16'hFFFE : mm_pkg::VIRQ_REL + irq2;

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            pend <= 3'h0;
            act  <= 3'h0;
        end else begin
            if (cfg_wr) begin
                pend <= reg_wdata[2:0];
            end
            if (key_wr && reg_wdata == mm_pkg::KEY_MAP) begin
                act[2:1] <= pend[2:1];
            end
            if (key_wr && reg_wdata == mm_pkg::KEY_RSTOFF) begin
                act[0] <= pend[0];
            end
        end
    end

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);

    ram_code_a: assert property (act[1] && code_win |=> code_target == mm_pkg::TGT_RAM)
        else $error("code ram window not steered to ram");
    commit_gate_a: assert property (!act[1] && !serial_mode && code_win |=>
        code_target != mm_pkg::TGT_RAM)
        else $error("uncommitted ram bit reached code space");
    data_ram_a: assert property (data_win |=> data_target == mm_pkg::TGT_RAM)
        else $error("data ram window not steered to ram");
    vec_std_a: assert property (!act[2] |=> vec_addr == ($past(vec_is_irq) ?
        mm_pkg::VIRQ_STD + $past(irq2) : mm_pkg::VCALL_STD + $past(call2)))
        else $error("standard vector address wrong");
    vec_rel_a: assert property (act[2] |=> vec_addr == ($past(vec_is_irq) ?
        $past(rel_irq) : mm_pkg::VCALL_REL + $past(call2)))
        else $error("relocated vector address wrong");
    status_rd_a: assert property (key_rd |=> reg_rdata == {5'h00, $past(act)})
        else $error("status read does not show committed bits");
    cfg_rd_a: assert property (reg_rd && reg_addr == mm_pkg::CFG_ADDR |=>
        reg_rdata == {5'h00, $past(pend)})
        else $error("config read wrong");
    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside read answer");

    cover property (key_wr && reg_wdata == mm_pkg::KEY_MAP);
    cover property (act[2] && vec_is_irq);
    cover property (key_rd && act[1]);
endmodule : map_link_properties

// ### test/memory_map_commit_control_test.sv
// bench: both ends joined by the link, driven from the software port
// assumes the checker watches serial mode as well
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); end end
module memory_map_commit_control_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic               clock_in = 1'b0;
    logic               sys_rst_in = 1'b1;
    logic [15:0]        sw_addr = 16'h0;
    logic [7:0]         sw_wdata = 8'h0;
    logic               sw_wr = 1'b0;
    logic               sw_rd = 1'b0;
    logic [7:0]         sw_rdata;
    logic [15:0]        code_addr = 16'h0;
    logic [15:0]        data_addr = 16'h0;
    logic               vec_irq = 1'b0;
    logic [4:0]         vec_idx = 5'h0;
    mm_pkg::target_type code_tgt;
    mm_pkg::target_type data_tgt;
    logic [15:0]        vec_addr;
    logic               map_req = 1'b0;
    logic               map_ram = 1'b0;
    logic               map_vec = 1'b0;
    logic               ram_loader = 1'b0;
    logic               busy;
    logic               flag_clr = 1'b0;
    logic               serial = 1'b0;
    logic               ram_act, vec_act, rsd_act, fclr_act, boot_act;
    int                 errors = 0;
    int                 n_compared = 0;

    initial begin
        forever #2 clock_in = ~clock_in;
    end

    map_link_if map_link_if_i ();
    memory_map_commit_control memory_map_commit_control_i (.clock_in(clock_in),
        .sys_rst_in(sys_rst_in), .link(map_link_if_i.dev), .serial_prog_mode_in(serial),
        .reset_flag_clear_in(flag_clr), .ram_in_code_active_out(ram_act),
        .vector_relocate_active_out(vec_act), .reset_disable_out(rsd_act),
        .reset_flag_clear_out(fclr_act), .boot_rom_map_out(boot_act));
    map_cpu_port map_cpu_port_i (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
        .link(map_link_if_i.cpu), .sw_addr_in(sw_addr), .sw_wdata_in(sw_wdata),
        .sw_wr_in(sw_wr), .sw_rd_in(sw_rd), .sw_rdata_out(sw_rdata),
        .code_addr_in(code_addr), .data_addr_in(data_addr), .vec_is_irq_in(vec_irq),
        .vec_index_in(vec_idx), .code_target_out(code_tgt), .data_target_out(data_tgt),
        .vec_addr_out(vec_addr), .map_req_in(map_req), .map_ram_in(map_ram),
        .map_vec_in(map_vec), .ram_loader_in(ram_loader), .map_busy_out(busy));
    map_link_properties map_link_properties_i (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
        .reg_addr(map_link_if_i.reg_addr), .reg_wdata(map_link_if_i.reg_wdata),
        .reg_wr(map_link_if_i.reg_wr), .reg_rd(map_link_if_i.reg_rd), .serial_mode(serial),
        .reg_rdata(map_link_if_i.reg_rdata), .code_addr(map_link_if_i.code_addr),
        .data_addr(map_link_if_i.data_addr), .vec_is_irq(map_link_if_i.vec_is_irq),
        .vec_index(map_link_if_i.vec_index), .code_target(map_link_if_i.code_target),
        .data_target(map_link_if_i.data_target), .vec_addr(map_link_if_i.vec_addr));

    task automatic print_verdict();
        if (errors == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : print_verdict

    // an idle cycle follows every strobe
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clock_in);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge clock_in);
        sw_wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [7:0] e, input string nm);
        @(posedge clock_in);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge clock_in);
        sw_rd <= 1'b0;
        #1;
        `CHK(nm, e, sw_rdata)
    endtask : rd

    task automatic look(input logic [15:0] c, d, input logic i, input logic [4:0] x);
        @(posedge clock_in);
        code_addr <= c;
        data_addr <= d;
        vec_irq <= i;
        vec_idx <= x;
        @(posedge clock_in);
        #1;
    endtask : look

    task automatic helper(input logic r, v, l, er, ev);
        int n;
        @(posedge clock_in);
        map_req <= 1'b1;
        map_ram <= r;
        map_vec <= v;
        ram_loader <= l;
        @(posedge clock_in);
        map_req <= 1'b0;
        #1;
        n = 0;
        while (busy === 1'b1 && n < 10) begin
            @(posedge clock_in);
            #1;
            n++;
        end
        if (n == 10) begin
            errors++;
            print_verdict();
        end
        `CHK("busy cycles", 2, n)
        `CHK("ram active", er, ram_act)
        `CHK("vec active", ev, vec_act)
    endtask : helper

    task automatic chk_reset();
        rd(mm_pkg::CFG_ADDR, 8'h00, "cfg");
        rd(mm_pkg::KEY_ADDR, 8'h00, "status");
        rd(mm_pkg::FLASH_RB_ADDR, 8'h40, "flash readback");
        rd(16'h0FE0, 8'h00, "unmapped");
        `CHK("boot map", 1'b0, boot_act)
        look(16'h0040, 16'h0040, 1'b0, 5'h0);
        `CHK("code ram off", mm_pkg::TGT_TRAP, code_tgt)
        `CHK("data ram", mm_pkg::TGT_RAM, data_tgt)
        look(16'h1000, 16'h1000, 1'b0, 5'h0);
        `CHK("code boot off", mm_pkg::TGT_FLASH, code_tgt)
        `CHK("data boot off", mm_pkg::TGT_FLASH, data_tgt)
    endtask : chk_reset

    task automatic chk_commit();
        wr(mm_pkg::CFG_ADDR, 8'hFF);
        rd(mm_pkg::CFG_ADDR, 8'h07, "cfg");
        `CHK("ram pending", 1'b0, ram_act)
        wr(mm_pkg::KEY_ADDR, 8'h55);
        `CHK("bad key", 1'b0, ram_act)
        wr(mm_pkg::KEY_ADDR, mm_pkg::KEY_MAP);
        `CHK("ram commit", 1'b1, ram_act)
        `CHK("vec commit", 1'b1, vec_act)
        rd(mm_pkg::KEY_ADDR, 8'h06, "status");
        look(16'h0C3F, 16'h0C3F, 1'b0, 5'h0F);
        `CHK("code ram top", mm_pkg::TGT_RAM, code_tgt)
        `CHK("call rel", 16'h01BE, vec_addr)
        look(16'h0C40, 16'h0040, 1'b1, 5'h1A);
        `CHK("code past ram", mm_pkg::TGT_NONE, code_tgt)
        `CHK("irq rel", 16'h01FC, vec_addr)
        look(16'h0040, 16'h0040, 1'b1, 5'h1B);
        `CHK("reset vec", 16'hFFFE, vec_addr)
    endtask : chk_commit

    task automatic chk_keys();
        wr(mm_pkg::KEY_ADDR, mm_pkg::KEY_RSTOFF);
        `CHK("rst disable", 1'b1, rsd_act)
        rd(mm_pkg::KEY_ADDR, 8'h07, "status");
        flag_clr <= 1'b1;
        wr(mm_pkg::KEY_ADDR, mm_pkg::KEY_FCLR);
        `CHK("flag clear", 1'b1, fclr_act)
        wr(mm_pkg::CFG_ADDR, 8'h00);
        wr(mm_pkg::KEY_ADDR, mm_pkg::KEY_FCLR);
        `CHK("ram kept", 1'b1, ram_act)
        wr(mm_pkg::KEY_ADDR, mm_pkg::KEY_MAP);
        `CHK("ram off", 1'b0, ram_act)
        rd(mm_pkg::KEY_ADDR, 8'h01, "status");
        look(16'h0040, 16'h0040, 1'b0, 5'h1F);
        `CHK("call std", 16'hFFBE, vec_addr)
        look(16'h0040, 16'h0040, 1'b1, 5'h00);
        `CHK("irq std", 16'hFFC8, vec_addr)
    endtask : chk_keys

    task automatic chk_boot();
        wr(mm_pkg::FLASH_CTRL_ADDR, 8'h50);
        `CHK("boot pending", 1'b0, boot_act)
        rd(mm_pkg::FLASH_RB_ADDR, 8'h40, "flash readback");
        wr(mm_pkg::FLASH_KEY_ADDR, mm_pkg::KEY_FLASH);
        `CHK("boot commit", 1'b1, boot_act)
        rd(mm_pkg::FLASH_RB_ADDR, 8'h50, "flash readback");
        look(16'h1000, 16'h17FF, 1'b0, 5'h0);
        `CHK("code boot", mm_pkg::TGT_BOOT, code_tgt)
        `CHK("data boot", mm_pkg::TGT_BOOT, data_tgt)
        look(16'h1800, 16'h1800, 1'b0, 5'h0);
        `CHK("code past 2k", mm_pkg::TGT_FLASH, code_tgt)
        `CHK("data past 2k", mm_pkg::TGT_FLASH, data_tgt)
        serial <= 1'b1;
        look(16'h0040, 16'h1800, 1'b0, 5'h0);
        `CHK("ser ram", mm_pkg::TGT_RAM, code_tgt)
        `CHK("ser boot", mm_pkg::TGT_BOOT, data_tgt)
        wr(mm_pkg::FLASH_CTRL_ADDR, 8'h40);
        wr(mm_pkg::FLASH_KEY_ADDR, mm_pkg::KEY_FLASH);
        look(16'h1000, 16'h1000, 1'b0, 5'h0);
        `CHK("code unmapped", mm_pkg::TGT_FLASH, code_tgt)
    endtask : chk_boot

    initial begin
        repeat (12) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        chk_reset();
        chk_commit();
        chk_keys();
        chk_boot();
        helper(1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
        helper(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
        print_verdict();
    end
endmodule : memory_map_commit_control_test
